//--- shared/gpio_pkg.sv
// constants, types and helpers shared by the byte-wide port block
`default_nettype none
package gpio_pkg;

	// register indices; the byte address on the bus is four times the index
	localparam logic [15:0] LATCH_INDEX = 16'hffd9;
	localparam logic [15:0] DIR_INDEX   = 16'hffe9;

	// the index sits in these haddr bits, the low two bits must be zero
	localparam int INDEX_LSB = 2;
	localparam int INDEX_MSB = 17;

	// reset values and the fixed read-back of the write-only register
	localparam logic [7:0] DIR_RESET      = 8'h00;
	localparam logic [7:0] LATCH_RESET    = 8'h00;
	localparam logic [7:0] DIR_READ_VALUE = 8'hff;

	// ahb-lite encodings that this slave looks at
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic [1:0] HRESP_OKAY    = 2'h0;

	// which register an accepted transfer addresses
	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_LATCH,
		SEL_DIR
	} reg_sel_t;

	// address phase held over into the data phase
	typedef struct packed {
		logic     valid;
		logic     write;
		reg_sel_t target;
	} addr_phase_t;

	// drive towards the pads: level and active-low enable per pin
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] enable_n;
	} pad_drive_t;

	// read view of the shared address: pins where input, latch where output
	function automatic logic [7:0] port_view(input logic [7:0] dir,
		input logic [7:0] latch, input logic [7:0] pins);
		port_view = (dir & latch) | (~dir & pins);
	endfunction : port_view

endpackage : gpio_pkg
`default_nettype wire

//--- core/port_byte_regs.sv
// direction and output latch registers with the pad drive they produce
`timescale 1ns/1ps
`default_nettype none
module port_byte_regs
	import gpio_pkg::*;
#(
	parameter int PORT_W = 8
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              dir_we,
	input  wire logic              latch_we,
	input  wire logic [PORT_W-1:0] wdata,
	output logic      [PORT_W-1:0] dir,
	output logic      [PORT_W-1:0] latch,
	output pad_drive_t             pads
);

	// direction register, one bit per pin
	// write sets direction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir <= DIR_RESET;
		end else if (dir_we) begin
			dir <= wdata;
		end
	end

	// output latch; every bit stores, also those of input pins
	// full byte store
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch <= LATCH_RESET;
		end else if (latch_we) begin
			latch <= wdata;
		end
	end

	// pad drive comes straight from the two registers, no extra stage
	// latch drives outputs
	assign pads.level = latch;
	// enable low drives pin
	// input pins keep enable high, so a latch write never reaches them
	assign pads.enable_n = ~dir;

endmodule : port_byte_regs
`default_nettype wire

//--- core/byte_port.sv
// ahb-lite slave for the byte-wide port: direction and shared latch/pin address
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module byte_port
	import gpio_pkg::*;
#(
	parameter int PORT_W = 8
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic      [1:0]        hresp,
	input  wire logic [PORT_W-1:0] port_six_pins_in,
	output logic      [PORT_W-1:0] port_six_pins_out,
	output logic      [PORT_W-1:0] port_six_pins_oe_n
);

	// registers of the port as the sub-block keeps them
	logic [PORT_W-1:0] pin_direction_control;
	logic [PORT_W-1:0] pin_output_latch;
	pad_drive_t        pads;

	// address phase decode
	logic        transfer;
	logic        aligned;
	logic [15:0] index;
	logic        hit_latch;
	logic        hit_dir;
	reg_sel_t    next_target;
	addr_phase_t next_phase;

	// data phase state
	addr_phase_t phase;
	logic        dir_we;
	logic        latch_we;
	logic [7:0]  write_byte;

	// values a read in this address phase must see
	logic [PORT_W-1:0] eff_dir;
	logic [PORT_W-1:0] eff_latch;
	logic [7:0]        latch_view;
	logic [7:0]        next_rdata;
	logic              read_now;

	// the slave never stretches a transfer and never signals an error
	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY;

	// a transfer is taken when selected, active and the bus is ready
	assign transfer = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign aligned  = (haddr[1:0] == 2'h0);
	assign index    = haddr[INDEX_MSB:INDEX_LSB];

	assign hit_latch = aligned && (index == LATCH_INDEX);
	assign hit_dir   = aligned && (index == DIR_INDEX);

	// unmapped or misaligned addresses fall to none: read zero, write dropped
	assign next_target = hit_latch ? SEL_LATCH : (hit_dir ? SEL_DIR : SEL_NONE);

	assign next_phase.valid  = transfer;
	assign next_phase.write  = hwrite;
	assign next_phase.target = next_target;

	// keep the address phase for the data phase that follows
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= '{valid: 1'b0, write: 1'b0, target: SEL_NONE};
		end else if (hready) begin
			phase <= next_phase;
		end
	end

	// write strobes act at the edge that closes the data phase
	// only the register byte lane is kept
	// a wider write still stores just bits 7:0, the remaining lanes are lost;
	// hsize is not checked so a careless word store cannot hang the port
	assign write_byte = hwdata[7:0];
	assign dir_we     = phase.valid && phase.write && (phase.target == SEL_DIR) && hready;
	assign latch_we   = phase.valid && phase.write && (phase.target == SEL_LATCH) && hready;

	// a read taken while a write is in its data phase sees the written byte;
	// without this the read half of a bit set after a store would be stale
	// back-to-back read forwarding
	assign eff_dir   = dir_we ? write_byte : pin_direction_control;
	assign eff_latch = latch_we ? write_byte : pin_output_latch;

	// shared address read: pin level for inputs, latch for outputs
	// input bits read pins
	assign latch_view = port_view(eff_dir, eff_latch, port_six_pins_in);

	// read value chosen in the address phase, returned from a flop
	// direction reads all ones
	assign read_now   = transfer && !hwrite;
	assign next_rdata = (next_target == SEL_LATCH) ? latch_view :
		((next_target == SEL_DIR) ? DIR_READ_VALUE : 8'h00);

	// read data register; bits above the byte always read zero
	// pins are sampled at the address phase edge, so a level that changes in
	// the data phase is seen only by the next read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (read_now) begin
			hrdata <= {24'h00_0000, next_rdata};
		end
	end

	// direction and latch registers with their pad drive
	port_byte_regs #(
		.PORT_W (PORT_W)
	) u_regs (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.dir_we   (dir_we),
		.latch_we (latch_we),
		.wdata    (write_byte),
		.dir      (pin_direction_control),
		.latch    (pin_output_latch),
		.pads     (pads)
	);

	// pads: level from the latch, enable low where the pin is an output
	// output pins follow latch
	assign port_six_pins_out  = pads.level;
	assign port_six_pins_oe_n = pads.enable_n;

endmodule : byte_port
`default_nettype wire

//--- bench/byte_port_asserts.sv
// checker for the byte port slave
`timescale 1ns/1ps
`default_nettype none
module byte_port_asserts
	import gpio_pkg::*;
(
	input wire logic        hclk, hresetn, hsel, hwrite, hready,
	input wire logic [1:0]  htrans,
	input wire logic [31:0] haddr, hwdata, hrdata,
	input wire logic [7:0]  port_six_pins_in, port_six_pins_out, port_six_pins_oe_n
);
	// decode; address bits above the index are ignored
	wire tk = hsel && hready && htrans[1], rd = tk && !hwrite;
	wire al = haddr[17:0] == {LATCH_INDEX, 2'h0};
	wire ad = haddr[17:0] == {DIR_INDEX, 2'h0};
	wire [7:0] wb = hwdata[7:0], rb = hrdata[7:0], pi = port_six_pins_in;
	wire [7:0] po = port_six_pins_out, pe = port_six_pins_oe_n;
	logic lw, dw;
	// marks a data phase that writes latch or direction
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn) {lw, dw} <= 2'h0;
		else {lw, dw} <= {tk && hwrite && al, tk && hwrite && ad};
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_dir_ones: assert property (rd && ad |=> hrdata == 32'hff) else $error("dir read");
	a_in_pins: assert property (rd && al |=> ((rb ^ $past(pi)) & pe) == 8'h0)
		else $error("input bits");
	a_out_latch: assert property (rd && al |=> ((rb ^ po) & ~pe) == 8'h0)
		else $error("output bits");
	a_latch_drive: assert property (lw |=> po == $past(wb)) else $error("drive");
	a_dir_enable: assert property (dw |=> pe == ~$past(wb)) else $error("enable");
	a_latch_hold: assert property (!lw |=> $stable(po)) else $error("drive moved");
	a_reset_in: assert property ($rose(hresetn) |-> pe == 8'hff && po == 8'h0)
		else $error("reset state");
	a_upper_zero: assert property (rd |=> hrdata[31:8] == 24'h0) else $error("upper");
endmodule : byte_port_asserts
bind byte_port byte_port_asserts chk (.hclk, .hresetn, .hsel, .hwrite, .hready, .htrans,
	.haddr, .hwdata, .hrdata, .port_six_pins_in, .port_six_pins_out, .port_six_pins_oe_n);
`default_nettype wire

//--- bench/pin_load.sv
// circuitry outside the port pins
`timescale 1ns/1ps
`default_nettype none
module pin_load (
	input  wire logic [7:0] drv, drv_oe_n, ext,
	output logic      [7:0] lvl
);
	// a driven pin reads the port level, an undriven one the outside source
	assign lvl = (~drv_oe_n & drv) | (drv_oe_n & ext);
endmodule : pin_load
`default_nettype wire

//--- bench/byte_port_tb_top.sv
// bench for the byte port slave
`timescale 1ns/1ps
`default_nettype none
module byte_port_tb_top;
	import gpio_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, hreadyout;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
	logic [7:0] ext = 8'h40, pins_in, pins_out, oe_n;
	int bad_count = 0, cmp_count = 0;
	localparam logic [31:0] LA = {14'h0, LATCH_INDEX, 2'h0}, DA = {14'h0, DIR_INDEX, 2'h0};
	// slave under test; its own ready closes the bus loop
	byte_port uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h0), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp(), .port_six_pins_in(pins_in),
		.port_six_pins_out(pins_out), .port_six_pins_oe_n(oe_n));
	pin_load pl (.drv(pins_out), .drv_oe_n(oe_n), .ext(ext), .lvl(pins_in));
	initial forever #4 hclk = ~hclk;
	task automatic check(input logic [7:0] s, e);
		cmp_count++;
		if (s !== e) bad_count++;
		if (s !== e) $display("[ERR] %0t saw %h want %h", $time, s, e);
	endtask : check
	// one transfer; each phase holds until ready is seen at an edge
	task automatic xfer(input logic w, input logic [31:0] a, d);
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		v = hrdata;
		#1;
	endtask : xfer
	task automatic finish_test();
		$display("%0d compares %0d mismatches", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	// hang guard; the tests need well under 100 cycles
	initial begin
		repeat (1000) @(posedge hclk);
		bad_count++;
		finish_test();
	end
	// set-up and reads, then bit edits in place and from a shadow byte
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		check(oe_n, 8'hff);
		xfer(1'b0, 32'h100, 32'h0);
		check(v[7:0], 8'h00);
		xfer(1'b1, DA, 32'h3f);
		check(oe_n, 8'hc0);
		xfer(1'b1, LA, 32'h85);
		check(pins_out, 8'h85);
		check(pins_in & 8'hc0, 8'h40);
		xfer(1'b0, LA, 32'h0);
		check(v[7:0], 8'h45);
		check(v[7:0] & 8'h3f, 8'h05);
		$display("test access done");
		xfer(1'b1, LA, v | 32'h2);
		check(pins_out, 8'h47);
		xfer(1'b1, LA, 32'h12345687);
		check(pins_out, 8'h87);
		xfer(1'b0, DA, 32'h0);
		check(v[7:0], 8'hff);
		xfer(1'b1, DA, v & 32'hfe);
		check(oe_n, 8'h01);
		xfer(1'b1, DA, 32'h3e);
		check(oe_n, 8'hc1);
		$display("test bit edit done");
		finish_test();
	end
endmodule : byte_port_tb_top
`default_nettype wire
